//--- scix_flag_alu.sv
// package of opcodes and widths for the system control executer, plus the
// combinational flag logic unit it uses
// assumes a single clock domain; instruction words come from fetch logic
`timescale 1ns/1ps
`default_nettype none
package scix_pkg;
    // ==========================================
    // widths
    localparam int WORD_W = 16;
    localparam int FLAG_W = 8;
    localparam int VEC_W = 2;
    // ==========================================
    // opcodes, held in instruction bits 15:8
    localparam logic [7:0] OP_NOP = 8'h01;
    localparam logic [7:0] OP_SLEEP = 8'h02;
    localparam logic [7:0] OP_RETEX = 8'h03;
    localparam logic [7:0] OP_TRAP = 8'h04;
    localparam logic [7:0] OP_LOADF_IMM = 8'h05;
    localparam logic [7:0] OP_LOADF_REG = 8'h06;
    localparam logic [7:0] OP_LOADF_MEM = 8'h07;
    localparam logic [7:0] OP_STOREF_REG = 8'h08;
    localparam logic [7:0] OP_STOREF_MEM = 8'h09;
    localparam logic [7:0] OP_AND_F = 8'h0A;
    localparam logic [7:0] OP_OR_F = 8'h0B;
    localparam logic [7:0] OP_XOR_F = 8'h0C;
    // ==========================================
    // reset values and timing
    localparam logic [7:0] FLAGS_RST = 8'h80;
    localparam int MEM_STATES = 2;
    // ==========================================
    // executer states
    typedef enum logic [4:0]
    {
        S_IDLE = 5'h01,
        S_RD1 = 5'h02,
        S_RD2 = 5'h04,
        S_WR1 = 5'h08,
        S_WR2 = 5'h10
    } scix_state_t;
endpackage

module scix_flag_alu
(
    input wire logic [7:0] op,
    input wire logic [scix_pkg::FLAG_W-1:0] flags,
    input wire logic [scix_pkg::FLAG_W-1:0] imm,
    output logic hit,
    output logic [scix_pkg::FLAG_W-1:0] result
);
    import scix_pkg::*;
    // ==========================================
    // byte-wide flag logic
    always_comb
    begin
        hit = 1'b1;
        case (op)
            OP_AND_F: result = flags & imm;
            OP_OR_F: result = flags | imm;
            OP_XOR_F: result = flags ^ imm;
            default:
            begin
                hit = 1'b0;
                result = flags;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- scix_exec.sv
// system control instruction executer: trap, return, sleep, flag load,
// flag store, flag logic and no-operation
// assumes fetch, register file and memory all run on SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module scix_exec
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic INSTR_VALID,
    input wire logic [scix_pkg::WORD_W-1:0] INSTR_WORD,
    input wire logic [scix_pkg::WORD_W-1:0] OPERAND_ADDR,
    output logic INSTR_READY,
    input wire logic [scix_pkg::WORD_W-1:0] REG_RDATA,
    output logic REG_WE,
    output logic [scix_pkg::WORD_W-1:0] REG_WDATA,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [scix_pkg::WORD_W-1:0] MEM_ADDR,
    output logic [scix_pkg::WORD_W-1:0] MEM_WDATA,
    input wire logic [scix_pkg::WORD_W-1:0] MEM_RDATA,
    output logic [scix_pkg::FLAG_W-1:0] CONDITION_FLAGS,
    output logic TRAP_START,
    output logic [scix_pkg::VEC_W-1:0] TRAP_VECTOR,
    output logic RETURN_START,
    output logic SLEEP_REQ,
    output logic PC_INC2
);
    import scix_pkg::*;

    typedef struct packed
    {
        scix_state_t st;
        logic [FLAG_W-1:0] flags;
        logic trap;
        logic [VEC_W-1:0] vec;
        logic ret;
        logic sleep;
        logic pc2;
        logic reg_we;
        logic [WORD_W-1:0] reg_wdata;
        logic mem_req;
        logic mem_we;
        logic [WORD_W-1:0] mem_addr;
        logic [WORD_W-1:0] mem_wdata;
    } scix_regs_t;

    scix_regs_t r_q;
    scix_regs_t r_d;
    logic accept;
    logic [7:0] op;
    logic alu_hit;
    logic [FLAG_W-1:0] alu_res;

    // ==========================================
    // decode
    assign INSTR_READY = (r_q.st == S_IDLE);
    assign accept = INSTR_VALID && INSTR_READY;
    assign op = INSTR_WORD[15:8];

    scix_flag_alu u_alu
    (
        .op(op),
        .flags(r_q.flags),
        .imm(INSTR_WORD[7:0]),
        .hit(alu_hit),
        .result(alu_res)
    );

    // ==========================================
    // next state
    always_comb
    begin
        r_d = r_q;
        r_d.trap = 1'b0;
        r_d.ret = 1'b0;
        r_d.sleep = 1'b0;
        r_d.pc2 = 1'b0;
        r_d.reg_we = 1'b0;
        case (r_q.st)
            S_IDLE:
            begin
                if (accept)
                begin
                    if (alu_hit)
                    begin
                        r_d.flags = alu_res;
                    end
                    case (op)
                        OP_NOP: r_d.pc2 = 1'b1;
                        OP_SLEEP: r_d.sleep = 1'b1;
                        OP_RETEX: r_d.ret = 1'b1;
                        OP_TRAP:
                        begin
                            r_d.trap = 1'b1;
                            r_d.vec = INSTR_WORD[VEC_W-1:0];
                        end
                        OP_LOADF_IMM: r_d.flags = INSTR_WORD[7:0];
                        OP_LOADF_REG: r_d.flags = REG_RDATA[7:0];
                        OP_LOADF_MEM:
                        begin
                            r_d.st = S_RD1;
                            r_d.mem_req = 1'b1;
                            r_d.mem_we = 1'b0;
                            r_d.mem_addr = OPERAND_ADDR;
                        end
                        OP_STOREF_REG:
                        begin
                            r_d.reg_we = 1'b1;
                            r_d.reg_wdata = {8'h00, r_q.flags};
                        end
                        OP_STOREF_MEM:
                        begin
                            r_d.st = S_WR1;
                            r_d.mem_req = 1'b1;
                            r_d.mem_we = 1'b1;
                            r_d.mem_addr = OPERAND_ADDR;
                            r_d.mem_wdata = {8'h00, r_q.flags};
                        end
                        default: r_d.pc2 = 1'b0;
                    endcase
                end
            end
            S_RD1: r_d.st = S_RD2;
            S_RD2:
            begin
                r_d.st = S_IDLE;
                r_d.mem_req = 1'b0;
                r_d.flags = MEM_RDATA[7:0];
            end
            S_WR1: r_d.st = S_WR2;
            S_WR2:
            begin
                r_d.st = S_IDLE;
                r_d.mem_req = 1'b0;
                r_d.mem_we = 1'b0;
            end
            default: r_d.st = S_IDLE;
        endcase
    end

    // ==========================================
    // state register
    always_ff @(posedge SYS_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            r_q <= '0;
            r_q.st <= S_IDLE;
            r_q.flags <= FLAGS_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ==========================================
    // outputs
    assign REG_WE = r_q.reg_we;
    assign REG_WDATA = r_q.reg_wdata;
    assign MEM_REQ = r_q.mem_req;
    assign MEM_WE = r_q.mem_we;
    assign MEM_ADDR = r_q.mem_addr;
    assign MEM_WDATA = r_q.mem_wdata;
    assign CONDITION_FLAGS = r_q.flags;
    assign TRAP_START = r_q.trap;
    assign TRAP_VECTOR = r_q.vec;
    assign RETURN_START = r_q.ret;
    assign SLEEP_REQ = r_q.sleep;
    assign PC_INC2 = r_q.pc2;

    // ==========================================
    // checks
    a_trap_start: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_TRAP |=> (TRAP_START
            && TRAP_VECTOR == $past(INSTR_WORD[VEC_W-1:0]))
            ##1 (!TRAP_START || $past(accept && op == OP_TRAP)))
        else $error("trap start missing");
    a_return_pulse: assert property (@(posedge SYS_CLK)
        disable iff (RESET) RETURN_START |-> $past(accept && op == OP_RETEX))
        else $error("return pulse without cause");
    a_sleep_req: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_SLEEP |=> SLEEP_REQ
            && $stable(CONDITION_FLAGS))
        else $error("sleep request missing");
    a_mem_flag_load: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_LOADF_MEM |=> ##2
            CONDITION_FLAGS == $past(MEM_RDATA[7:0]))
        else $error("flag load from memory wrong");
    a_mem_flag_store: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_STOREF_MEM |=> MEM_WE
            && MEM_WDATA == {8'h00, $past(CONDITION_FLAGS)})
        else $error("flag store word wrong");
    a_and_flags: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_AND_F |=> CONDITION_FLAGS
            == ($past(CONDITION_FLAGS) & $past(INSTR_WORD[7:0])))
        else $error("and flags wrong");
    a_or_flags: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_OR_F |=> CONDITION_FLAGS
            == ($past(CONDITION_FLAGS) | $past(INSTR_WORD[7:0])))
        else $error("or flags wrong");
    a_xor_flags: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_XOR_F |=> CONDITION_FLAGS
            == ($past(CONDITION_FLAGS) ^ $past(INSTR_WORD[7:0])))
        else $error("xor flags wrong");
    a_nop_only_pc: assert property (@(posedge SYS_CLK)
        disable iff (RESET) accept && op == OP_NOP |=> PC_INC2
            && $stable(CONDITION_FLAGS) && !MEM_REQ
            && !REG_WE && !TRAP_START)
        else $error("no-operation changed state");
    a_mem_two_states: assert property (@(posedge SYS_CLK)
        disable iff (RESET) $rose(MEM_REQ) |-> MEM_REQ [*2] ##1 !MEM_REQ)
        else $error("memory access not two states");
    a_busy_not_ready: assert property (@(posedge SYS_CLK)
        disable iff (RESET) MEM_REQ |-> !INSTR_READY)
        else $error("ready during memory access");
endmodule
`default_nettype wire

//--- scix_mem_model.sv
// program memory model answering word reads and writes
// assumes requests change just after rising edges of sys_clk
`timescale 1ns/1ps
`default_nettype none
module scix_mem_model
(
    input wire logic sys_clk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [scix_pkg::WORD_W-1:0] mem_addr,
    input wire logic [scix_pkg::WORD_W-1:0] mem_wdata,
    output logic [scix_pkg::WORD_W-1:0] mem_rdata
);
    import scix_pkg::*;
    logic [WORD_W-1:0] mem [0:15];
    logic [WORD_W-1:0] last_q = 16'h0000;
    // ==========================================
    // word read, inverted last word when idle
    always_comb
    begin
        if (mem_req && !mem_we)
            mem_rdata = mem[mem_addr[3:0]];
        else
            mem_rdata = ~last_q;
    end
    always @(posedge sys_clk)
    begin
        if (mem_req && !mem_we)
            last_q <= mem_rdata;
        if (mem_req && mem_we)
            mem[mem_addr[3:0]] <= mem_wdata;
    end
endmodule
`default_nettype wire

//--- tb_scix_exec.sv
// self-checking bench for the system control executer
// assumes scix_pkg and scix_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_scix_exec;
    import scix_pkg::*;
    localparam logic [4:0][7:0] ops = {8'hFF, OP_TRAP, OP_RETEX, OP_SLEEP,
        OP_NOP};
    localparam logic [4:0][3:0] pul = {4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic iv = 1'b0;
    logic [15:0] iw = 16'h0000;
    logic [15:0] ia = 16'h0000;
    logic [15:0] rr = 16'h1233;
    logic rdy, rwe, mreq, mwe, trap, ret, slp, pc2;
    logic [15:0] rwd, madr, mwd, mrd;
    logic [7:0] flg;
    logic [1:0] vec;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    scix_exec u_dut
    (
        .SYS_CLK(clk), .RESET(rst), .INSTR_VALID(iv), .INSTR_WORD(iw),
        .OPERAND_ADDR(ia), .INSTR_READY(rdy), .REG_RDATA(rr), .REG_WE(rwe),
        .REG_WDATA(rwd), .MEM_REQ(mreq), .MEM_WE(mwe), .MEM_ADDR(madr),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd), .CONDITION_FLAGS(flg),
        .TRAP_START(trap), .TRAP_VECTOR(vec), .RETURN_START(ret),
        .SLEEP_REQ(slp), .PC_INC2(pc2)
    );
    scix_mem_model u_mem
    (
        .sys_clk(clk), .mem_req(mreq), .mem_we(mwe), .mem_addr(madr),
        .mem_wdata(mwd), .mem_rdata(mrd)
    );
    // ==========================================
    // shared tasks
    task automatic give_verdict();
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [15:0] w, input logic [15:0] a);
        @(posedge clk);
        iv <= 1'b1;
        iw <= w;
        ia <= a;
        @(posedge clk);
        iv <= 1'b0;
        @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            failures++;
            give_verdict();
        end
    end
    // ==========================================
    // scenarios
    task automatic t_flags();
        step({OP_LOADF_IMM, 8'h5A}, 16'h0000);
        chk(16'(flg), 16'h005A);
        step({OP_AND_F, 8'h0F}, 16'h0000);
        chk(16'(flg), 16'h000A);
        step({OP_OR_F, 8'hF0}, 16'h0000);
        chk(16'(flg), 16'h00FA);
        step({OP_XOR_F, 8'hFF}, 16'h0000);
        chk(16'(flg), 16'h0005);
        @(posedge clk);
        iv <= 1'b1;
        iw <= {OP_AND_F, 8'h0F};
        @(posedge clk);
        iw <= {OP_OR_F, 8'h30};
        @(posedge clk);
        iv <= 1'b0;
        @(negedge clk);
        chk(16'(flg), 16'h0035);
    endtask
    task automatic t_reg();
        step({OP_LOADF_REG, 8'h00}, 16'h0000);
        chk(16'(flg), 16'h0033);
        step({OP_STOREF_REG, 8'h00}, 16'h0000);
        chk(16'(rwe), 16'h0001);
        chk(rwd, 16'h0033);
        @(negedge clk);
        chk(16'(rwe), 16'h0000);
    endtask
    task automatic t_mem();
        step({OP_LOADF_MEM, 8'h00}, 16'h0003);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0004);
        chk(madr, 16'h0003);
        @(negedge clk);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0004);
        @(negedge clk);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0001);
        chk(16'(flg), 16'h0077);
        step({OP_STOREF_MEM, 8'h00}, 16'h0005);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0006);
        chk(mwd, 16'h0077);
        @(negedge clk);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0006);
        @(negedge clk);
        chk({13'h0000, mreq, mwe, rdy}, 16'h0001);
        chk(u_mem.mem[5], 16'h0077);
    endtask
    task automatic t_ctrl();
        for (int i = 0; i < 5; i++)
        begin
            step({ops[i], 8'h03}, 16'h0000);
            chk(16'({trap, ret, slp, pc2}), 16'(pul[i]));
            chk(16'(flg), 16'h0077);
            if (i == 3)
                chk(16'(vec), 16'h0003);
            @(negedge clk);
            chk(16'({trap, ret, slp, pc2}), 16'h0000);
        end
    endtask
    task automatic t_rst();
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        chk(16'(flg), 16'h0080);
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({flg, 7'h00, rdy}, 16'h8001);
    endtask
    initial
    begin
        u_mem.mem[3] = 16'hAB77;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({flg, 6'h00, rdy, mreq}, 16'h8002);
        t_flags();
        t_reg();
        t_mem();
        t_ctrl();
        t_rst();
        give_verdict();
    end
endmodule
`default_nettype wire
